// ==== core/low_voltage_detect_ctrl.sv ====
`timescale 1ns/1ps
module low_voltage_detect_ctrl (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        DET_RST_I,
    // CPU register access
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    input  wire logic [15:0] ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    output logic      [7:0]  RDATA_O,
    // Analog comparator results, asynchronous, 1 = below
    input  wire logic        SUPPLY_BELOW_I,
    input  wire logic        EXT_BELOW_I,
    // Analog control
    output logic             CMP_EN_O,
    output logic             THRESHOLD_CHOICE_O,
    output logic             EXT_SEL_O,
    // Port 12 pin drivers
    input  wire logic [2:0]  PORT12_LATCH_I,
    output logic      [2:0]  PORT12_OE_O,
    output logic      [2:0]  PORT12_OUT_O,
    // Chip reset and interrupt
    output logic             DET_RESET_REQ_O,
    output logic             DETECTOR_IRQ_O,
    output logic             DETECTOR_IRQ_PENDING_O,
    output logic             DETECTOR_RESET_CAUSE_O
);
    lvd_pkg::cpu_req_type req;
    lvd_pkg::cmp_type     cmp_raw;
    lvd_pkg::cmp_type     cmp;
    logic       detector_enable_r;
    logic       source_select_r;
    logic       reset_mode_select_r;
    logic       threshold_choice_bit_r;
    logic [2:0] pin_direction_bits_r;
    logic       detector_irq_mask_r;
    logic       below_prev_r;
    logic       below_sel;
    logic       below_level_flag;
    logic       crossing;
    logic       disable_below;
    logic       irq_event;
    logic       ctrl_wr;
    logic       irq_wr;

    assign req     = '{wr: WR_I, rd: RD_I, addr: ADDR_I, wdata: WDATA_I};
    assign cmp_raw = '{supply_below: SUPPLY_BELOW_I, ext_below: EXT_BELOW_I};
    assign ctrl_wr = req.wr && (req.addr == lvd_pkg::CTRL_ADDR);
    assign irq_wr  = req.wr && (req.addr == lvd_pkg::IRQ_ADDR);

    // Comparators are asynchronous to the clock
    lvd_sync u_sync (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .d_i     (cmp_raw),
        .q_o     (cmp)
    );

    // Selected comparison; external path ignores the level select
    assign below_sel        = source_select_r ? cmp.ext_below : cmp.supply_below;
    assign below_level_flag = detector_enable_r & below_sel;

    // Crossing in either direction while enabled in interrupt use
    assign crossing      = detector_enable_r && !reset_mode_select_r
                           && (below_level_flag != below_prev_r);
    // Turning off while below counts as a rising crossing
    assign disable_below = ctrl_wr && !req.wdata[lvd_pkg::EN_BIT] && detector_enable_r
                           && !reset_mode_select_r && below_level_flag;
    assign irq_event     = crossing || disable_below;

    // Control register: kept across detector reset only
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I && !DET_RST_I) begin
            detector_enable_r   <= lvd_pkg::CTRL_RST[lvd_pkg::EN_BIT];
            source_select_r     <= lvd_pkg::CTRL_RST[lvd_pkg::SRC_BIT];
            reset_mode_select_r <= lvd_pkg::CTRL_RST[lvd_pkg::MODE_BIT];
        end else if (RST_N_I && ctrl_wr) begin
            detector_enable_r   <= req.wdata[lvd_pkg::EN_BIT];
            source_select_r     <= req.wdata[lvd_pkg::SRC_BIT];
            reset_mode_select_r <= req.wdata[lvd_pkg::MODE_BIT];
        end
    end

    // Level select: kept across detector reset only
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I && !DET_RST_I) begin
            threshold_choice_bit_r <= lvd_pkg::LEVEL_RST[0];
        end else if (RST_N_I && req.wr && req.addr == lvd_pkg::LEVEL_ADDR) begin
            threshold_choice_bit_r <= req.wdata[0];
        end
    end

    // Port 12 direction, reset to all inputs on any reset
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            pin_direction_bits_r <= lvd_pkg::DIR12_RST[2:0];
        end else if (req.wr && req.addr == lvd_pkg::DIR12_ADDR) begin
            pin_direction_bits_r <= req.wdata[2:0];
        end
    end

    // Pin drivers: a 0 direction bit turns the driver on
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            PORT12_OE_O  <= 3'h0;
            PORT12_OUT_O <= 3'h0;
        end else begin
            PORT12_OE_O  <= ~pin_direction_bits_r;
            PORT12_OUT_O <= PORT12_LATCH_I;
        end
    end

    // Interrupt mask, masked after any reset
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            detector_irq_mask_r <= 1'b1;
        end else if (irq_wr) begin
            detector_irq_mask_r <= req.wdata[lvd_pkg::MASK_BIT];
        end
    end

    // Pending flag; a new event wins over a software clear
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            DETECTOR_IRQ_PENDING_O <= 1'b0;
        end else if (irq_event) begin
            DETECTOR_IRQ_PENDING_O <= 1'b1;
        end else if (irq_wr) begin
            DETECTOR_IRQ_PENDING_O <= req.wdata[lvd_pkg::PEND_BIT];
        end
    end

    // Edge history and one-cycle unmasked request
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            below_prev_r   <= 1'b0;
            DETECTOR_IRQ_O <= 1'b0;
        end else begin
            below_prev_r   <= below_level_flag;
            DETECTOR_IRQ_O <= irq_event && !detector_irq_mask_r;
        end
    end

    // Reset request is a level; it only follows the live compare,
    // so setting mode while above never fires
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I && !DET_RST_I) begin
            DET_RESET_REQ_O <= 1'b0;
        end else begin
            DET_RESET_REQ_O <= reset_mode_select_r && below_level_flag;
        end
    end

    // Reset cause: set by detector reset, cleared by other resets or read
    always_ff @(posedge CLK_I) begin
        if (DET_RST_I) begin
            DETECTOR_RESET_CAUSE_O <= 1'b1;
        end else if (!RST_N_I) begin
            DETECTOR_RESET_CAUSE_O <= 1'b0;
        end else if (req.rd && req.addr == lvd_pkg::CAUSE_ADDR) begin
            DETECTOR_RESET_CAUSE_O <= 1'b0;
        end
    end

    // Analog controls
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I && !DET_RST_I) begin
            CMP_EN_O           <= 1'b0;
            THRESHOLD_CHOICE_O <= lvd_pkg::THR_HIGH;
            EXT_SEL_O          <= 1'b0;
        end else begin
            CMP_EN_O           <= detector_enable_r;
            THRESHOLD_CHOICE_O <= threshold_choice_bit_r;
            EXT_SEL_O          <= source_select_r;
        end
    end

    // Registered read mux; unmapped reads return zero
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            RDATA_O <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                lvd_pkg::CTRL_ADDR:  RDATA_O <= {detector_enable_r, 4'h0, source_select_r,
                                                 reset_mode_select_r, below_level_flag};
                lvd_pkg::LEVEL_ADDR: RDATA_O <= {7'h00, threshold_choice_bit_r};
                lvd_pkg::DIR12_ADDR: RDATA_O <= lvd_pkg::DIR12_FIXED
                                                | {5'h00, pin_direction_bits_r};
                lvd_pkg::IRQ_ADDR:   RDATA_O <= {6'h00, detector_irq_mask_r,
                                                 DETECTOR_IRQ_PENDING_O};
                lvd_pkg::CAUSE_ADDR: RDATA_O <= {7'h00, DETECTOR_RESET_CAUSE_O};
                default:             RDATA_O <= 8'h00;
            endcase
        end
    end
endmodule : low_voltage_detect_ctrl

// ==== core/lvd_pkg.sv ====
package lvd_pkg;

    // Register addresses
    localparam logic [15:0] CTRL_ADDR      = 16'hffbe;
    localparam logic [15:0] LEVEL_ADDR     = 16'hffbf;
    localparam logic [15:0] DIR12_ADDR     = 16'hff2c;
    localparam logic [15:0] IRQ_ADDR       = 16'hffe0;
    localparam logic [15:0] CAUSE_ADDR     = 16'hfff8;

    // Reset values
    localparam logic [7:0]  CTRL_RST       = 8'h00;
    localparam logic [7:0]  LEVEL_RST      = 8'h00;
    localparam logic [7:0]  DIR12_RST      = 8'hff;
    localparam logic [7:0]  DIR12_FIXED    = 8'hf8;

    // Control register field positions
    localparam int          EN_BIT         = 7;
    localparam int          SRC_BIT        = 2;
    localparam int          MODE_BIT       = 1;
    localparam int          FLAG_BIT       = 0;

    // Irq control register (own): bit 0 pending, bit 1 mask
    localparam int          PEND_BIT       = 0;
    localparam int          MASK_BIT       = 1;
    localparam int          CAUSE_BIT      = 0;
    localparam int          DIR_BITS       = 3;

    // Threshold choice encodings
    localparam logic        THR_HIGH       = 1'b0;
    localparam logic        THR_LOW        = 1'b1;

    // CPU register access
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cpu_req_type;

    // Synchronised comparator results (1 = below threshold)
    typedef struct packed {
        logic supply_below;
        logic ext_below;
    } cmp_type;

endpackage : lvd_pkg

// ==== core/lvd_sync.sv ====
`timescale 1ns/1ps
// Two-stage synchroniser for the comparator outputs
module lvd_sync (
    input  wire logic            clk_i,
    input  wire logic            rst_n_i,
    input  wire lvd_pkg::cmp_type d_i,
    output lvd_pkg::cmp_type     q_o
);
    lvd_pkg::cmp_type meta_r;

    // First stage only feeds the second
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            q_o    <= '0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule : lvd_sync

// ==== dv/low_voltage_detect_ctrl_tb.sv ====
`timescale 1ns/1ps
module low_voltage_detect_ctrl_tb;
    logic        clk = 0, rst_n = 0, det_rst = 0, wr = 0, rd = 0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00, rdata;
    logic [2:0]  latch = 3'h0, oe, pout;
    logic [12:0] vdd = 13'h1130, ext = 13'h0514;
    logic        s_b, e_b, en, thr, esel, req, irq, pend, cause;
    int          fails = 0, checked = 0, cycles = 0;
    always #2 clk = ~clk;
    lvd_analog_model lvd_analog_model_inst (.threshold_choice_i(thr), .vdd_mv_i(vdd),
        .ext_mv_i(ext), .supply_below_o(s_b), .ext_below_o(e_b));
    low_voltage_detect_ctrl low_voltage_detect_ctrl_inst (.CLK_I(clk), .RST_N_I(rst_n),
        .DET_RST_I(det_rst), .WR_I(wr), .RD_I(rd), .ADDR_I(addr), .WDATA_I(wdata),
        .RDATA_O(rdata), .SUPPLY_BELOW_I(s_b), .EXT_BELOW_I(e_b), .CMP_EN_O(en),
        .THRESHOLD_CHOICE_O(thr), .EXT_SEL_O(esel), .PORT12_LATCH_I(latch),
        .PORT12_OE_O(oe), .PORT12_OUT_O(pout), .DET_RESET_REQ_O(req),
        .DETECTOR_IRQ_O(irq), .DETECTOR_IRQ_PENDING_O(pend), .DETECTOR_RESET_CAUSE_O(cause));
    task results;
        if (fails == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
            fails++;
        end
    endtask : chk
    task wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk) wr = 1; addr = a; wdata = d;
        @(negedge clk) wr = 0;
    endtask : wr_reg
    task rd_chk(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk) rd = 1; addr = a;
        @(negedge clk) rd = 0;
        chk(rdata, e);
    endtask : rd_chk
    task rst(input logic d);
        @(negedge clk) rst_n = 0; det_rst = d;
        repeat (2) @(negedge clk);
        rst_n = 1; det_rst = 0;
    endtask : rst
    // Pulse stands one cycle, so look at every falling edge
    task wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(irq, 1'b1);
    endtask : wait_irq
    // Hang guard, the run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            results();
        end
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1;
        rd_chk(lvd_pkg::DIR12_ADDR, 8'hff);
        rd_chk(lvd_pkg::CTRL_ADDR, 8'h00);
        rd_chk(lvd_pkg::LEVEL_ADDR, 8'h00);
        rd_chk(lvd_pkg::IRQ_ADDR, 8'h02);
        rd_chk(16'h1234, 8'h00);
        latch = 3'h5;
        wr_reg(lvd_pkg::DIR12_ADDR, 8'h02);
        // Driver enables are one flop behind the direction register
        @(negedge clk);
        chk(oe, 3'h5);
        chk(pout, 3'h5);
        rd_chk(lvd_pkg::DIR12_ADDR, 8'hfa);
        wr_reg(lvd_pkg::DIR12_ADDR, 8'h01);
        @(negedge clk);
        chk(oe, 3'h6);
        // 4150 mV sits between the two supply levels
        vdd = 13'h1036;
        wr_reg(lvd_pkg::LEVEL_ADDR, 8'h01);
        wr_reg(lvd_pkg::CTRL_ADDR, 8'h80);
        repeat (4) @(negedge clk);
        rd_chk(lvd_pkg::CTRL_ADDR, 8'h80);
        wr_reg(lvd_pkg::CTRL_ADDR, 8'h00);
        wr_reg(lvd_pkg::LEVEL_ADDR, 8'h00);
        wr_reg(lvd_pkg::CTRL_ADDR, 8'h80);
        repeat (4) @(negedge clk);
        rd_chk(lvd_pkg::CTRL_ADDR, 8'h81);
        chk(pend, 1'b1);
        wr_reg(lvd_pkg::IRQ_ADDR, 8'h00);
        chk(pend, 1'b0);
        vdd = 13'h10cc;
        wait_irq();
        vdd = 13'h0fa0;
        wait_irq();
        wr_reg(lvd_pkg::IRQ_ADDR, 8'h02);
        wr_reg(lvd_pkg::CTRL_ADDR, 8'h00);
        repeat (4) @(negedge clk);
        chk(pend, 1'b1);
        rd_chk(lvd_pkg::CTRL_ADDR, 8'h00);
        // Supply below both levels, external pin decides alone
        wr_reg(lvd_pkg::LEVEL_ADDR, 8'h01);
        wr_reg(lvd_pkg::CTRL_ADDR, 8'h84);
        repeat (4) @(negedge clk);
        rd_chk(lvd_pkg::CTRL_ADDR, 8'h84);
        ext = 13'h03e8;
        repeat (4) @(negedge clk);
        rd_chk(lvd_pkg::CTRL_ADDR, 8'h85);
        ext = 13'h0514;
        // Mode is set only once the flag reads above level
        wr_reg(lvd_pkg::CTRL_ADDR, 8'h86);
        repeat (6) @(negedge clk);
        chk(req, 1'b0);
        ext = 13'h03e8;
        repeat (6) @(negedge clk);
        chk(req, 1'b1);
        ext = 13'h0514;
        rst(1'b1);
        chk(cause, 1'b1);
        rd_chk(lvd_pkg::CTRL_ADDR, 8'h86);
        rd_chk(lvd_pkg::LEVEL_ADDR, 8'h01);
        chk(req, 1'b0);
        rd_chk(lvd_pkg::CAUSE_ADDR, 8'h01);
        chk(cause, 1'b0);
        wr_reg(lvd_pkg::CTRL_ADDR, 8'h00);
        rst(1'b0);
        rd_chk(lvd_pkg::LEVEL_ADDR, 8'h00);
        rd_chk(lvd_pkg::IRQ_ADDR, 8'h02);
        rd_chk(lvd_pkg::DIR12_ADDR, 8'hff);
        results();
    end
endmodule : low_voltage_detect_ctrl_tb

// ==== dv/lvd_analog_model.sv ====
`timescale 1ns/1ps
// Behavioural comparators on the far side of the detector
module lvd_analog_model (
    // Voltages in millivolts and level choice
    input  wire logic        threshold_choice_i,
    input  wire logic [12:0] vdd_mv_i,
    input  wire logic [12:0] ext_mv_i,
    // Comparator results, 1 = below
    output logic             supply_below_o,
    output logic             ext_below_o
);
    // Choice 0 is 4240 mV, 1 is 4090 mV
    assign supply_below_o = vdd_mv_i < (threshold_choice_i ? 13'h0ffa : 13'h1090);
    // Fixed 1210 mV, level choice has no say here
    assign ext_below_o    = ext_mv_i < 13'h04ba;
endmodule : lvd_analog_model

// ==== dv/lvd_props.sv ====
`timescale 1ns/1ps
// Port-level checks of the detector control block
module lvd_props (
    input wire logic        CLK_I,
    input wire logic        RST_N_I,
    input wire logic        DET_RST_I,
    input wire logic        WR_I,
    input wire logic        RD_I,
    input wire logic [15:0] ADDR_I,
    input wire logic [7:0]  WDATA_I,
    input wire logic [7:0]  RDATA_O,
    input wire logic        SUPPLY_BELOW_I,
    input wire logic        EXT_BELOW_I,
    input wire logic        CMP_EN_O,
    input wire logic        THRESHOLD_CHOICE_O,
    input wire logic        EXT_SEL_O,
    input wire logic [2:0]  PORT12_OE_O,
    input wire logic        DET_RESET_REQ_O,
    input wire logic        DETECTOR_IRQ_O,
    input wire logic        DETECTOR_IRQ_PENDING_O,
    input wire logic        DETECTOR_RESET_CAUSE_O
);
    // Raw result of the source in use; sync delay is three edges to the request
    logic sel_below;
    assign sel_below = EXT_SEL_O ? EXT_BELOW_I : SUPPLY_BELOW_I;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Register then output flop, so the pins follow a write two edges later
    a_ctrl_write: assert property (WR_I && ADDR_I == lvd_pkg::CTRL_ADDR |-> ##2
        CMP_EN_O == $past(WDATA_I[7], 2) && EXT_SEL_O == $past(WDATA_I[2], 2))
        else $error("ctrl write");
    a_level_write: assert property (WR_I && ADDR_I == lvd_pkg::LEVEL_ADDR |-> ##2
        THRESHOLD_CHOICE_O == $past(WDATA_I[0], 2)) else $error("level write");
    a_dir_read: assert property (RD_I && ADDR_I == lvd_pkg::DIR12_ADDR |=>
        RDATA_O[7:3] == 5'h1f && RDATA_O[2:0] == ~PORT12_OE_O) else $error("dir read");
    a_plain_reset: assert property ($rose(RST_N_I) && !$past(DET_RST_I) |->
        PORT12_OE_O == 3'h0 && !CMP_EN_O && !EXT_SEL_O && !THRESHOLD_CHOICE_O
        && !DETECTOR_IRQ_PENDING_O) else $error("plain reset values");
    a_det_keep: assert property ($rose(RST_N_I) && $past(DET_RST_I) |->
        DETECTOR_RESET_CAUSE_O && CMP_EN_O == $past(CMP_EN_O, 3)
        && THRESHOLD_CHOICE_O == $past(THRESHOLD_CHOICE_O, 3)) else $error("detector reset");
    a_req_cause: assert property ($rose(DET_RESET_REQ_O) |-> $past(sel_below, 3))
        else $error("reset request without low level");
    a_req_release: assert property (!sel_below [*4] |-> !DET_RESET_REQ_O)
        else $error("reset request held above level");
    a_off_quiet: assert property (!CMP_EN_O [*4] |-> !DET_RESET_REQ_O)
        else $error("reset request while disabled");
    a_irq_pending: assert property (DETECTOR_IRQ_O |-> DETECTOR_IRQ_PENDING_O)
        else $error("irq without pending");
endmodule : lvd_props
bind low_voltage_detect_ctrl lvd_props lvd_props_inst (.CLK_I, .RST_N_I, .DET_RST_I, .WR_I,
    .RD_I, .ADDR_I, .WDATA_I, .RDATA_O, .SUPPLY_BELOW_I, .EXT_BELOW_I, .CMP_EN_O,
    .THRESHOLD_CHOICE_O, .EXT_SEL_O, .PORT12_OE_O, .DET_RESET_REQ_O, .DETECTOR_IRQ_O,
    .DETECTOR_IRQ_PENDING_O, .DETECTOR_RESET_CAUSE_O);
